// file: hw/phsp_pkg.sv
// Constants, field layouts and carrier types of the parallel handshake port
package phsp_pkg;

  localparam int DW = 16;
  localparam int AW = 8;

  // Register offsets (byte addresses)
  localparam logic [AW-1:0] CTRL_OFS   = 8'h00;
  localparam logic [AW-1:0] CFG_OFS    = 8'h04;
  localparam logic [AW-1:0] DOUT_OFS   = 8'h08;
  localparam logic [AW-1:0] DIN_OFS    = 8'h0C;
  localparam logic [AW-1:0] XFER_OFS   = 8'h10;
  localparam logic [AW-1:0] STATUS_OFS = 8'h14;

  // Control register fields
  localparam int CTRL_RST_BIT  = 0;
  localparam int CTRL_RDYIE    = 1;
  localparam int CTRL_EIRIE    = 2;
  localparam int CTRL_UOUT_LSB = 3;

  // Configuration register fields
  localparam int CFG_INPOL    = 0;
  localparam int CFG_OUTPOL   = 1;
  localparam int CFG_STBHI    = 2;
  localparam int CFG_ACKHI    = 3;
  localparam int CFG_PULSE    = 4;
  localparam int CFG_CAP_LSB  = 5;
  localparam int CFG_OKEN     = 7;
  localparam int CFG_OKPOL    = 8;
  localparam int CFG_DOCLR    = 9;
  localparam int CFG_PRIO_LSB = 10;
  localparam int CFG_W        = 12;
  localparam logic [CFG_W-1:0] CFG_RESET = 12'h003;

  // Capture edge choices
  localparam logic [1:0] CAP_BUSY  = 2'h0;
  localparam logic [1:0] CAP_READY = 2'h1;
  localparam logic [1:0] CAP_READ  = 2'h2;

  // Transfer register fields
  localparam int XFER_DIR_BIT = 0;
  localparam int XFER_RDY_BIT = 1;

  // Status register fields
  localparam int ST_READY   = 0;
  localparam int ST_BUSY    = 1;
  localparam int ST_ERR     = 2;
  localparam int ST_OK      = 3;
  localparam int ST_EIR     = 4;
  localparam int ST_UIN_LSB = 5;
  localparam int ST_DONE    = 7;
  localparam int ST_CODE_LSB = 8;

  localparam logic [7:0] ERR_NOT_OK = 8'hAC;
  localparam logic [2:0] PRIO_BASE  = 3'h3;

  // Peripheral reset pulse timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int PRST_TIME_US  = 15;
  localparam int RCW           = 12;
  localparam logic [RCW-1:0] PRST_CYCLES =
    RCW'((PRST_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  typedef enum logic [2:0] {
    XS_IDLE, XS_OKCHK, XS_RDYCHK, XS_DIRSET, XS_STROBE, XS_WAITACK, XS_FINISH
  } phsp_xs_t;

  // Lines driven toward the peripheral
  typedef struct packed {
    logic [DW-1:0] output_data_bus;
    logic          transfer_strobe_out;
    logic          direction_out;
    logic          periph_reset_n_out;
    logic          user_out_0;
    logic          user_out_1;
    logic          irq_out;
    logic [2:0]    irq_level;
  } phsp_pins_out_t;

  // Lines sensed from the peripheral
  typedef struct packed {
    logic [DW-1:0] input_data_bus;
    logic          peripheral_ack_in;
    logic          peripheral_ok_in;
    logic          external_irq_in_n;
    logic          user_in_0;
    logic          user_in_1;
  } phsp_pins_in_t;

  localparam int PIN_IN_W = DW + 5;

endpackage

// file: hw/phsp_sync.sv
// Two-flop synchroniser bank for the peripheral inputs
`timescale 1ns/1ps
module phsp_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// file: hw/phsp_port.sv
// Parallel handshake port with APB register access
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps

// Notes on behaviour
// - Separate 16-bit input and 16-bit output data buses.
// - Port drives the strobe and asserts it to start each transfer.
// - Direction line high for input, low for output, never inverted.
// - External request interrupts only when enabled; its level stays readable.
// - Two user outputs set by software, two user inputs sampled.
// - Data lines low-true by default; input polarity 0 gives high-true input.
// - Output polarity 1 inverts output sense; both polarities reset to 1.
// - Strobe and acknowledge active levels each selectable.
// - Optional OK and ready checks, then direction, then strobe.
// - Option selects full or pulse handshake mode.
// - Output data held stable while the strobe is set.
// - Capture option picks which acknowledge transition, or a read of the input data register, latches input data.
// - Optional one-time OK check with selectable sense; failure gives code 172.
// - OK check behaves the same in both handshake modes.
// - Port reset drives peripheral reset low for at least 15 us.
// - Port reset clears the strobe and the interrupt enables.
// - Port reset clears output data only when clear-on-reset is set.
// - Port reset keeps user outputs and direction line unchanged.
// - Interrupt priority selectable from level 3 to 6.
// - Ready is strobe clear plus ack ready (full) or strobe clear (pulse).
// - Pulse: ack clears strobe. Full: done when strobe clear and ack ready.
module phsp_port (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [phsp_pkg::AW-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire phsp_pkg::phsp_pins_in_t pins_in,
  output phsp_pkg::phsp_pins_out_t     pins_out
);
  import phsp_pkg::*;

  typedef struct packed {
    phsp_xs_t         st;
    logic [RCW-1:0]   rst_cnt;
    logic [CFG_W-1:0] cfg;
    logic             rdy_ie;
    logic             eir_ie;
    logic [1:0]       uout;
    logic [DW-1:0]    dout;
    logic [DW-1:0]    din;
    logic             dir;
    logic             dir_req;
    logic             rdy_chk;
    logic             strobe;
    logic             ack_prev;
    logic             err;
    logic             done;
    logic [7:0]       err_code;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    phsp_pins_out_t   pins;
  } phsp_state_t;

  phsp_state_t   s_reg;
  phsp_state_t   s_next;
  phsp_pins_in_t pin_s;

  // Peripheral lines pass two flops before use
  phsp_sync #(
    .W (PIN_IN_W)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pins_in),
    .sync_out (pin_s)
  );

  logic          wr_take;
  logic          rd_setup;
  logic          ack_rdy;
  logic          ack_busy_edge;
  logic          ack_rdy_edge;
  logic          pulse_mode;
  logic          port_ready;
  logic          ok_good;
  logic          in_reset;
  logic          eir_low;
  logic [DW-1:0] din_live;
  logic [1:0]    cap_sel;
  logic [31:0]   status_word;

  // Decoded conditions from current state and synced lines
  always_comb
  begin
    wr_take  = psel && penable && s_reg.pready && pwrite;
    rd_setup = psel && !penable && !pwrite;
    pulse_mode = s_reg.cfg[CFG_PULSE];
    ack_rdy  = (pin_s.peripheral_ack_in == s_reg.cfg[CFG_ACKHI]);
    // Acknowledge transitions against the last cycle
    ack_busy_edge = s_reg.ack_prev && !ack_rdy;
    ack_rdy_edge  = !s_reg.ack_prev && ack_rdy;
    port_ready = !s_reg.strobe && (pulse_mode || ack_rdy);
    ok_good  = (pin_s.peripheral_ok_in == s_reg.cfg[CFG_OKPOL]);
    in_reset = (s_reg.rst_cnt != '0);
    eir_low  = !pin_s.external_irq_in_n;
    din_live = pin_s.input_data_bus ^ {DW{s_reg.cfg[CFG_INPOL]}};
    cap_sel  = s_reg.cfg[CFG_CAP_LSB +: 2];
    // Status word from live lines and sticky flags
    status_word = '0;
    status_word[ST_READY] = port_ready && (s_reg.st == XS_IDLE);
    status_word[ST_BUSY]  = (s_reg.st != XS_IDLE) || in_reset;
    status_word[ST_ERR]   = s_reg.err;
    status_word[ST_OK]    = ok_good;
    status_word[ST_EIR]   = eir_low;
    status_word[ST_UIN_LSB]     = pin_s.user_in_0;
    status_word[ST_UIN_LSB + 1] = pin_s.user_in_1;
    status_word[ST_DONE]  = s_reg.done;
    status_word[ST_CODE_LSB +: 8] = s_reg.err_code;
  end

  // Next-state logic for the whole port
  always_comb
  begin
    s_next = s_reg;
    s_next.ack_prev = ack_rdy;

    // APB answer: data prepared in setup, ready in first access cycle
    s_next.pready  = psel && !penable;
    s_next.pslverr = 1'b0;
    s_next.prdata  = '0;

    // Read data picked by address in the setup cycle
    if (psel && !penable)
    begin
      if (paddr == CTRL_OFS)
      begin
        s_next.prdata[CTRL_RDYIE] = s_reg.rdy_ie;
        s_next.prdata[CTRL_EIRIE] = s_reg.eir_ie;
        s_next.prdata[CTRL_UOUT_LSB +: 2] = s_reg.uout;
      end
      else if (paddr == CFG_OFS)
        s_next.prdata[CFG_W-1:0] = s_reg.cfg;
      else if (paddr == DOUT_OFS)
        s_next.prdata[DW-1:0] = s_reg.dout;
      else if (paddr == DIN_OFS)
      begin
        if (cap_sel == CAP_READ && rd_setup)
          s_next.prdata[DW-1:0] = din_live;
        else
          s_next.prdata[DW-1:0] = s_reg.din;
      end
      else if (paddr == XFER_OFS)
      begin
        s_next.prdata[XFER_DIR_BIT] = s_reg.dir;
        s_next.prdata[XFER_RDY_BIT] = s_reg.rdy_chk;
      end
      else if (paddr == STATUS_OFS)
        s_next.prdata = status_word;
      else
        s_next.pslverr = 1'b1;
    end

    // Read-clocked capture of the input data
    if (rd_setup && paddr == DIN_OFS && cap_sel == CAP_READ)
      s_next.din = din_live;

    // Acknowledge-edge capture during input transfers
    if (s_reg.dir && cap_sel == CAP_BUSY && ack_busy_edge)
      s_next.din = din_live;
    if (s_reg.dir && cap_sel == CAP_READY && ack_rdy_edge)
      s_next.din = din_live;

    // Register writes
    if (wr_take)
    begin
      if (paddr == CTRL_OFS)
      begin
        s_next.rdy_ie = pwdata[CTRL_RDYIE];
        s_next.eir_ie = pwdata[CTRL_EIRIE];
        s_next.uout   = pwdata[CTRL_UOUT_LSB +: 2];
      end
      else if (paddr == CFG_OFS)
        s_next.cfg = pwdata[CFG_W-1:0];
      else if (paddr == DOUT_OFS && !s_reg.strobe)
        s_next.dout = pwdata[DW-1:0];
      else if (paddr == STATUS_OFS)
      begin
        if (pwdata[ST_ERR])
          s_next.err = 1'b0;
        if (pwdata[ST_DONE])
          s_next.done = 1'b0;
      end
    end

    // Transfer sequencer
    case (s_reg.st)
      // Wait for a start write; keep its direction for later
      XS_IDLE:
      begin
        if (wr_take && paddr == XFER_OFS && !in_reset)
        begin
          s_next.dir_req = pwdata[XFER_DIR_BIT];
          s_next.rdy_chk = pwdata[XFER_RDY_BIT];
          s_next.st      = XS_OKCHK;
        end
      end

      // Optional one-time peripheral OK check
      XS_OKCHK:
      begin
        if (s_reg.cfg[CFG_OKEN] && !ok_good)
        begin
          s_next.err      = 1'b1;
          s_next.err_code = ERR_NOT_OK;
          s_next.st       = XS_IDLE;
        end
        else if (s_reg.rdy_chk)
          s_next.st = XS_RDYCHK;
        else
          s_next.st = XS_DIRSET;
      end

      // Optional wait for the port-ready condition
      XS_RDYCHK:
      begin
        if (port_ready)
          s_next.st = XS_DIRSET;
      end

      // Direction line set before the strobe
      XS_DIRSET:
      begin
        s_next.dir = s_reg.dir_req;
        s_next.st  = XS_STROBE;
      end

      // Strobe raised one cycle after direction
      XS_STROBE:
      begin
        s_next.strobe = 1'b1;
        s_next.st     = XS_WAITACK;
      end

      // Acknowledge going busy clears the strobe
      XS_WAITACK:
      begin
        if (ack_busy_edge)
        begin
          s_next.strobe = 1'b0;
          if (pulse_mode)
          begin
            s_next.done = 1'b1;
            s_next.st   = XS_IDLE;
          end
          else
            s_next.st = XS_FINISH;
        end
      end

      // Full mode ends once acknowledge is ready again
      XS_FINISH:
      begin
        if (ack_rdy)
        begin
          s_next.done = 1'b1;
          s_next.st   = XS_IDLE;
        end
      end

      // Unused codes fall back to idle
      default:
        s_next.st = XS_IDLE;
    endcase

    // Port reset request starts the peripheral reset pulse
    if (wr_take && paddr == CTRL_OFS && pwdata[CTRL_RST_BIT])
      s_next.rst_cnt = PRST_CYCLES;
    else if (in_reset)
      s_next.rst_cnt = s_reg.rst_cnt - RCW'(1);

    // Reset effects; user outputs and direction are left alone
    if (in_reset || s_next.rst_cnt != '0)
    begin
      s_next.strobe = 1'b0;
      s_next.rdy_ie = 1'b0;
      s_next.eir_ie = 1'b0;
      s_next.st     = XS_IDLE;
      if (s_reg.cfg[CFG_DOCLR])
        s_next.dout = '0;
    end

    // Pin levels from next values so outputs come straight from flops
    s_next.pins.output_data_bus =
      s_next.dout ^ {DW{s_next.cfg[CFG_OUTPOL]}};
    s_next.pins.transfer_strobe_out =
      !(s_next.strobe ^ s_next.cfg[CFG_STBHI]);

    // Direction, peripheral reset and user lines
    s_next.pins.direction_out      = s_next.dir;
    s_next.pins.periph_reset_n_out = (s_next.rst_cnt == '0);
    s_next.pins.user_out_0         = s_next.uout[0];
    s_next.pins.user_out_1         = s_next.uout[1];

    // Interrupt request and its priority level
    s_next.pins.irq_out =
      (s_next.eir_ie && eir_low) ||
      (s_next.rdy_ie && port_ready && s_reg.st == XS_IDLE);
    s_next.pins.irq_level =
      PRIO_BASE + {1'b0, s_next.cfg[CFG_PRIO_LSB +: 2]};
  end

  // State register; reset also launches the peripheral reset pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg          <= '0;
      s_reg.st       <= XS_IDLE;
      s_reg.cfg      <= CFG_RESET;
      s_reg.rst_cnt  <= PRST_CYCLES;
      // Pins start at their idle levels
      s_reg.pins.output_data_bus     <= '1;
      s_reg.pins.transfer_strobe_out <= 1'b1;
      s_reg.pins.irq_level           <= PRIO_BASE;
    end
    else
      s_reg <= s_next;
  end

  // Outputs taken directly from state flops
  always_comb
  begin
    prdata   = s_reg.prdata;
    pready   = s_reg.pready;
    pslverr  = s_reg.pslverr;
    pins_out = s_reg.pins;
  end

endmodule

// file: tb/phsp_checker.sv
// Port-level assertions for the parallel handshake port
`timescale 1ns/1ps
module phsp_checker (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [phsp_pkg::AW-1:0]  paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire phsp_pkg::phsp_pins_in_t  pins_in,
  input wire phsp_pkg::phsp_pins_out_t pins_out
);
  import phsp_pkg::*;
  logic [CFG_W-1:0] cfg_reg;
  logic [1:0]       ie_reg;
  logic [RCW-1:0]   low_reg;
  logic             wr;
  logic             stb;
  // Committed write and strobe set level
  assign wr  = psel && penable && pready && pwrite;
  assign stb = pins_out.transfer_strobe_out == cfg_reg[CFG_STBHI];
  // Shadow config, enables and reset pulse length
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_reg <= CFG_RESET;
      ie_reg  <= 2'h0;
      low_reg <= '0;
    end
    else
    begin
      if (wr && paddr == CFG_OFS)
        cfg_reg <= pwdata[CFG_W-1:0];
      if (wr && paddr == CTRL_OFS)
        ie_reg <= pwdata[0] ? 2'h0 : pwdata[2:1];
      low_reg <= pins_out.periph_reset_n_out ? '0 : low_reg + 1'b1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  AST_APB_ANSWER: assert property (s_setup ##1 s_access |-> pready)
    else $error("access cycle without ready");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_DOUT_STABLE: assert property (stb ##1 stb |-> $stable(pins_out.output_data_bus))
    else $error("output data moved under strobe");
  AST_DIR_FIRST: assert property (!stb ##1 stb |-> $stable(pins_out.direction_out))
    else $error("direction changed with strobe");
  AST_PRIO: assert property ($stable(cfg_reg) |->
    pins_out.irq_level == PRIO_BASE + cfg_reg[CFG_PRIO_LSB+:2])
    else $error("priority level wrong");
  AST_PRST_LEN: assert property ($rose(pins_out.periph_reset_n_out) |->
    low_reg >= PRST_CYCLES - 1)
    else $error("peripheral reset too short");
  AST_RST_CLEAR: assert property (!pins_out.periph_reset_n_out ##1
    !pins_out.periph_reset_n_out |-> !stb && !pins_out.irq_out)
    else $error("strobe or interrupt live in reset");
  AST_KEEP_USER: assert property ($fell(pins_out.periph_reset_n_out) |->
    $stable({pins_out.user_out_0, pins_out.user_out_1, pins_out.direction_out}))
    else $error("reset changed kept lines");
  AST_IRQ_MASK: assert property ((ie_reg == 2'h0)[*3] |-> !pins_out.irq_out)
    else $error("interrupt while disabled");
  AST_EIR_FIRE: assert property ((ie_reg[1] && !pins_in.external_irq_in_n)[*5]
    |-> pins_out.irq_out)
    else $error("external request not raised");
endmodule
bind phsp_port phsp_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pins_in(pins_in), .pins_out(pins_out));

// file: tb/phsp_periph.sv
// Behavioural peripheral on the handshake lines
`timescale 1ns/1ps
module phsp_periph (
  input wire logic                     pclk,
  input wire logic                     stb_hi,
  input wire logic                     ack_hi,
  input wire logic                     hold,
  input wire logic [3:0]               delay,
  input wire logic [15:0]              word,
  input wire phsp_pkg::phsp_pins_out_t pins_out,
  output logic                         ack,
  output logic [15:0]                  din,
  output logic [15:0]                  got
);
  import phsp_pkg::*;
  logic s;
  logic p = 1'b0;
  // Strobe seen twice, then answer; idle bus shows inverse
  initial
  begin
    ack = 1'b0;
    din = ~word;
    forever
    begin
      @(posedge pclk);
      s = pins_out.transfer_strobe_out === stb_hi;
      if (s && p)
      begin
        if (pins_out.direction_out)
          din <= word;
        else
          got <= pins_out.output_data_bus;
        @(posedge pclk);
        repeat (delay) @(posedge pclk);
        ack <= ~ack_hi;
        while (pins_out.transfer_strobe_out === stb_hi)
          @(posedge pclk);
        repeat (delay) @(posedge pclk);
        ack <= ack_hi;
        repeat (3) @(posedge pclk);
        s = 1'b0;
      end
      else
      begin
        ack <= ack_hi;
        if (!hold)
          din <= ~word;
      end
      p = s;
    end
  end
endmodule

// file: tb/parallel_handshake_port_tb.sv
// Self-checking bench for the parallel handshake port
`timescale 1ns/1ps
module parallel_handshake_port_tb;
  import phsp_pkg::*;
  typedef struct packed {logic [31:0] m; logic [31:0] v; logic e;} phsp_note_t;
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [AW-1:0]    paddr = '0;
  logic [31:0]      pwdata = '0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  phsp_pins_in_t    pins_in;
  phsp_pins_out_t   pins_out;
  logic             ok = 1'b1;
  logic             eir_n = 1'b1;
  logic             hold = 1'b0;
  logic             ack;
  logic [1:0]       uin = 2'h0;
  logic [3:0]       dly = 4'h0;
  logic [15:0]      word = 16'h0000;
  logic [15:0]      w;
  logic [15:0]      got;
  logic [15:0]      din;
  logic [CFG_W-1:0] cfg = CFG_RESET;
  logic [31:0]      last_rd = '0;
  phsp_note_t       nt;
  phsp_note_t       q[$];
  int               n_mismatch = 0;
  int               tests_run = 0;
  int               seed = 21011;
  // Clock and input pin bundle
  always #2.5 pclk = ~pclk;
  assign pins_in = '{din, ack, ok, eir_n, uin[0], uin[1]};
  phsp_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins_in(pins_in), .pins_out(pins_out));
  phsp_periph u_per (.pclk(pclk), .stb_hi(cfg[CFG_STBHI]), .ack_hi(cfg[CFG_ACKHI]),
    .hold(hold), .delay(dly), .word(word), .pins_out(pins_out), .ack(ack), .din(din),
    .got(got));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (e !== s)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic wt, input logic [AW-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wt;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [31:0] m, v, input logic e);
    q.push_back('{m, v, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic setcfg(input logic [CFG_W-1:0] c);
    wr(CFG_OFS, 32'(c));
    cfg <= c;
  endtask
  task automatic wait_prst();
    int i;
    i = 0;
    repeat (2) @(posedge pclk);
    while (pins_out.periph_reset_n_out !== 1'b1 && i < 5000)
    begin
      @(posedge pclk);
      i++;
    end
    chk("prst_len", 32'd1, 32'(i > 2900 && i < 5000));
  endtask
  task automatic wait_done();
    int i;
    i = 0;
    last_rd = '0;
    while (last_rd[ST_DONE] !== 1'b1 && i < 100)
    begin
      rd(STATUS_OFS, 32'h0, 32'h0, 1'b0);
      i++;
    end
    rd(STATUS_OFS, 32'h86, 32'h80, 1'b0);
    wr(STATUS_OFS, 32'h84);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Read monitor takes the oldest note
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0)
    begin
      last_rd = prdata;
      nt = q.pop_front();
      if (nt.m != 0)
        chk("prdata", nt.v, prdata & nt.m);
      chk("pslverr", 32'(nt.e), 32'(pslverr));
    end
  // Watchdog
  initial
  begin
    #200000;
    n_mismatch++;
    stop_test();
  end
  // Main sequence
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk("dout_pins", 32'hFFFF, 32'(pins_out.output_data_bus));
    wait_prst();
    rd(CFG_OFS, 32'hFFF, 32'h003, 1'b0);
    rd(8'h18, 32'hFFFFFFFF, 32'h0, 1'b1);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      setcfg({2'(i), 5'h0, i[0], i[1], i[1], i[0], 1'b1});
      w = 16'($random(seed));
      dly <= 4'($random(seed));
      wr(DOUT_OFS, 32'(w));
      wr(XFER_OFS, {30'h0, i[0], 1'b0});
      wait_done();
      chk("out_word", 32'(w ^ {16{i[0]}}), 32'(got));
      chk("irq_level", 32'(3 + i), 32'(pins_out.irq_level));
      $display("test output %0d done", i);
    end
    for (int c = 0; c < 3; c++)
    begin
      setcfg({5'h0, 2'(c), 4'h1, c[0]});
      w = 16'($random(seed));
      word <= w;
      hold <= (c == 2);
      wr(XFER_OFS, 32'h1);
      wait_done();
      rd(DIN_OFS, 32'hFFFF, 32'(w ^ {16{c[0]}}), 1'b0);
      hold <= 1'b0;
      $display("test input %0d done", c);
    end
    ok <= 1'b0;
    for (int p = 0; p < 2; p++)
    begin
      setcfg({3'h0, 2'h3, 2'h0, p[0], 4'h3});
      wr(XFER_OFS, 32'h0);
      repeat (4) @(posedge pclk);
      rd(STATUS_OFS, 32'hFF06, 32'hAC04, 1'b0);
      wr(STATUS_OFS, 32'h84);
      $display("test ok check %0d done", p);
    end
    ok <= 1'b1;
    uin <= 2'($random(seed));
    eir_n <= 1'b0;
    wr(CTRL_OFS, 32'h1C);
    repeat (6) @(posedge pclk);
    chk("irq_out", 32'h1, 32'(pins_out.irq_out));
    chk("user_out", 32'h3, 32'({pins_out.user_out_1, pins_out.user_out_0}));
    rd(STATUS_OFS, 32'h70, 32'({uin, 1'b1, 4'h0}), 1'b0);
    eir_n <= 1'b1;
    wr(CTRL_OFS, 32'h1A);
    repeat (2) @(posedge pclk);
    chk("irq_ready", 32'h1, 32'(pins_out.irq_out));
    $display("test lines done");
    for (int d = 0; d < 2; d++)
    begin
      setcfg({2'h0, d[0], 9'h3});
      wr(DOUT_OFS, 32'h5A5A);
      wr(CTRL_OFS, 32'h1F);
      wait_prst();
      rd(CTRL_OFS, 32'h1F, 32'h18, 1'b0);
      rd(DOUT_OFS, 32'hFFFF, d ? 32'h0 : 32'h5A5A, 1'b0);
      rd(XFER_OFS, 32'h1, 32'h1, 1'b0);
      $display("test port reset %0d done", d);
    end
    stop_test();
  end
endmodule
